// ---- hw/rtc_pkg.sv ----
/*
 * Shared constants and types of the BCD clock/calendar core: register
 * map, field positions, reset values, timing figures and the serial
 * state encoding. Assumes a 200 MHz core clock and a 32.768 kHz crystal.
 */
package rtc_pkg;

  // serial slave address, upper seven bits of the slave byte
  localparam logic [6:0] SLAVE_ADDR = 7'h6f;

  // register offsets
  localparam logic [4:0] OFS_SEC = 5'h00;
  localparam logic [4:0] OFS_MIN = 5'h01;
  localparam logic [4:0] OFS_HOUR = 5'h02;
  localparam logic [4:0] OFS_DATE = 5'h03;
  localparam logic [4:0] OFS_MONTH = 5'h04;
  localparam logic [4:0] OFS_YEAR = 5'h05;
  localparam logic [4:0] OFS_DOW = 5'h06;
  localparam logic [4:0] OFS_STATUS = 5'h07;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_ALM1 = 5'h0c;
  localparam logic [4:0] OFS_ALM_LAST = 5'h14;

  // reset values
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] DATE_RST = 8'h01;
  localparam logic [7:0] MONTH_RST = 8'h01;
  localparam logic [7:0] STATUS_RST = 8'h09;
  localparam logic [7:0] CTRL_RST = 8'h18;

  // status_flags fields
  localparam int ST_AUTOCLR = 7;
  localparam int ST_OSCDIS = 6;
  localparam int ST_WREN = 4;
  localparam int ST_OSCFAIL = 3;
  localparam int ST_AL1 = 2;
  localparam int ST_AL2 = 1;
  localparam int ST_PWRLOSS = 0;

  // irq_and_fout_control fields
  localparam int CT_AL1EN = 6;
  localparam int CT_AL2EN = 5;
  localparam int CT_FSELHI = 4;
  localparam int CT_FSELLO = 3;
  localparam int CT_IRQSEL = 2;
  localparam int CT_AL1PIN = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h7d;

  // hours_count fields
  localparam int HOUR_FORMAT_24 = 7;
  localparam int HOUR_PM = 5;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int XTAL_PERIOD_NS = 30518;
  localparam int OSC_TIMEOUT_PERIODS = 4;
  localparam int OSC_TIMEOUT_CYC =
    (OSC_TIMEOUT_PERIODS * XTAL_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int PRESCALE_BITS = 15;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] dow;
  } time_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_ADDR_ACK = 4'h2,
    S_REG = 4'h3,
    S_REG_ACK = 4'h4,
    S_WR = 4'h5,
    S_WR_ACK = 4'h6,
    S_RD = 4'h7,
    S_RD_ACK = 4'h8
  } serial_state_t;

endpackage

// ---- hw/rtc_core.sv ----
/*
 * BCD real time clock core with status/control registers, two alarms,
 * shared interrupt/frequency pin and serial slave register port.
 * Assumes scl, sda and the crystal level arrive asynchronously; reset
 * stands for power-up after a complete supply loss.
 */
`timescale 1ns/1ps
module rtc_core
  import rtc_pkg::*;
#(
  parameter int OSC_TIMEOUT = OSC_TIMEOUT_CYC,
  parameter int PRESC_W = PRESCALE_BITS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // crystal
  input wire logic crystalInPin,
  output logic crystalEnable,
  // interrupt / frequency pin
  output logic irqFoutOut,
  output logic irqFoutOe_n
);

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // input synchronisers, third stage only for edge detection
  logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3, xtS1, xtS2, xtS3;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {sclS1, sclS2, sclS3} <= 3'h7;
      {sdaS1, sdaS2, sdaS3} <= 3'h7;
      {xtS1, xtS2, xtS3} <= 3'h0;
    end
    else
    begin
      {sclS1, sclS2, sclS3} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
      {xtS1, xtS2, xtS3} <= {crystalInPin, xtS1, xtS2};
    end
  end

  wire sclRise = sclS2 & ~sclS3;
  wire sclFall = ~sclS2 & sclS3;
  wire busStart = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  wire busStop = sclS2 & sclS3 & ~sdaS3 & sdaS2;

  // state
  time_t tm_r, tmNxt, tmAdv, snap_r;
  logic [7:0] status_r, ctrl_r, shift_r, outByte_r;
  logic [7:0] alarm_r [0:8];
  logic [4:0] ptr_r;
  logic [3:0] bitCnt_r;
  serial_state_t st_r;
  logic rwRead_r, sdaDrv_r, ackSeen_r, statusRead_r, timeWritten_r;
  logic running_r, tickDly_r, oscGone_r, pinOut_r, pinOe_n_r;
  logic [PRESC_W-1:0] presc_r;
  logic [31:0] oscWd_r;

  // serial decode
  wire byteDone = sclFall && bitCnt_r == 4'h8;
  wire wrStb = byteDone && st_r == S_WR;
  wire isTime = ptr_r <= OFS_DOW;
  wire timeWr = wrStb && isTime && status_r[ST_WREN];
  wire stWr = wrStb && ptr_r == OFS_STATUS;
  wire ctWr = wrStb && ptr_r == OFS_CTRL;
  wire almWr = wrStb && ptr_r >= OFS_ALM1 && ptr_r <= OFS_ALM_LAST;
  wire [4:0] almIdx = ptr_r - OFS_ALM1;
  wire addrHit = shift_r[7:1] == SLAVE_ADDR;

  // byte returned for the current pointer; time from the snapshot
  logic [7:0] rdData;
  always_comb
  begin
    rdData = 8'h00;
    unique case (ptr_r)
      OFS_SEC: rdData = snap_r.sec;
      OFS_MIN: rdData = snap_r.min;
      OFS_HOUR: rdData = snap_r.hour;
      OFS_DATE: rdData = snap_r.date;
      OFS_MONTH: rdData = snap_r.month;
      OFS_YEAR: rdData = snap_r.year;
      OFS_DOW: rdData = snap_r.dow;
      OFS_STATUS: rdData = status_r;
      OFS_CTRL: rdData = ctrl_r;
      default:
        if (ptr_r >= OFS_ALM1 && ptr_r <= OFS_ALM_LAST)
          rdData = alarm_r[almIdx[3:0]];
    endcase
  end

  // serial slave engine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 5'h00;
      rwRead_r <= 1'b0;
      sdaDrv_r <= 1'b0;
      ackSeen_r <= 1'b0;
      outByte_r <= 8'h00;
    end
    else if (busStart)
    begin
      st_r <= S_ADDR;
      bitCnt_r <= 4'h0;
      sdaDrv_r <= 1'b0;
    end
    else if (busStop)
    begin
      st_r <= S_IDLE;
      sdaDrv_r <= 1'b0;
    end
    else if (sclRise)
    begin
      if (st_r == S_RD_ACK)
        ackSeen_r <= ~sdaS2;
      else if (st_r == S_ADDR || st_r == S_REG || st_r == S_WR)
      begin
        shift_r <= {shift_r[6:0], sdaS2};
        bitCnt_r <= bitCnt_r + 4'h1;
      end
      else if (st_r == S_RD)
        bitCnt_r <= bitCnt_r + 4'h1;
    end
    else if (sclFall)
    begin
      unique case (st_r)
        S_IDLE: st_r <= S_IDLE;
        S_ADDR:
          if (bitCnt_r == 4'h8)
          begin
            st_r <= addrHit ? S_ADDR_ACK : S_IDLE;
            sdaDrv_r <= addrHit;
            rwRead_r <= shift_r[0];
          end
        S_ADDR_ACK:
        begin
          bitCnt_r <= 4'h0;
          st_r <= rwRead_r ? S_RD : S_REG;
          sdaDrv_r <= rwRead_r & ~rdData[7];
          outByte_r <= {rdData[6:0], 1'b0};
        end
        S_REG:
          if (bitCnt_r == 4'h8)
          begin
            ptr_r <= shift_r[4:0];
            st_r <= S_REG_ACK;
            sdaDrv_r <= 1'b1;
          end
        S_WR:
          if (bitCnt_r == 4'h8)
          begin
            st_r <= S_WR_ACK;
            sdaDrv_r <= 1'b1;
          end
        S_REG_ACK, S_WR_ACK:
        begin
          if (st_r == S_WR_ACK)
            ptr_r <= ptr_r + 5'h01;
          st_r <= S_WR;
          bitCnt_r <= 4'h0;
          sdaDrv_r <= 1'b0;
        end
        S_RD:
          if (bitCnt_r == 4'h8)
          begin
            st_r <= S_RD_ACK;
            sdaDrv_r <= 1'b0;
            ptr_r <= ptr_r + 5'h01;
          end
          else
          begin
            sdaDrv_r <= ~outByte_r[7];
            outByte_r <= {outByte_r[6:0], 1'b0};
          end
        S_RD_ACK:
        begin
          bitCnt_r <= 4'h0;
          st_r <= ackSeen_r ? S_RD : S_IDLE;
          sdaDrv_r <= ackSeen_r & ~rdData[7];
          outByte_r <= {rdData[6:0], 1'b0};
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  wire loadRd = sclFall && (st_r == S_ADDR_ACK && rwRead_r ||
    st_r == S_RD_ACK && ackSeen_r);
  wire readStart = sclFall && st_r == S_ADDR && bitCnt_r == 4'h8 &&
    addrHit && shift_r[0];

  // crystal edges, prescaler and oscillator watchdog
  wire xtEdge = xtS2 & ~xtS3 & ~status_r[ST_OSCDIS];
  wire secTick = xtEdge && running_r && presc_r == '1;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_r <= '0;
      oscWd_r <= 32'h0;
      oscGone_r <= 1'b0;
      running_r <= 1'b0;
      timeWritten_r <= 1'b0;
      statusRead_r <= 1'b0;
      tickDly_r <= 1'b0;
    end
    else
    begin
      tickDly_r <= secTick;
      if (busStop && timeWritten_r)
        presc_r <= '0;
      else if (xtEdge)
        presc_r <= presc_r + 1'b1;
      if (busStop && timeWritten_r)
        running_r <= 1'b1;
      if (busStop || busStart)
        timeWritten_r <= 1'b0;
      else if (timeWr)
        timeWritten_r <= 1'b1;
      if (busStop || busStart)
        statusRead_r <= 1'b0;
      else if (loadRd && ptr_r == OFS_STATUS)
        statusRead_r <= 1'b1;
      oscWd_r <= xtEdge ? 32'h0 :
        (oscGone_r ? oscWd_r : oscWd_r + 32'h1);
      oscGone_r <= ~xtEdge && oscWd_r >= OSC_TIMEOUT - 1;
    end
  end

  // calendar advance, all carries resolved in one tick
  logic leap;
  logic [7:0] lastDay;
  assign leap = tm_r.year[4] ? (tm_r.year[3:0] == 4'h2 ||
    tm_r.year[3:0] == 4'h6) : (tm_r.year[3:0] == 4'h0 ||
    tm_r.year[3:0] == 4'h4 || tm_r.year[3:0] == 4'h8);
  always_comb
  begin
    unique case (tm_r.month)
      8'h02: lastDay = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
      default: lastDay = 8'h31;
    endcase
  end

  always_comb
  begin
    logic cMin, cHour, cDay, cMonth, cYear;
    logic [7:0] hInc;
    cMin = tm_r.sec == 8'h59;
    cHour = cMin && tm_r.min == 8'h59;
    cDay = 1'b0;
    cMonth = 1'b0;
    cYear = 1'b0;
    hInc = bcdInc({3'h0, tm_r.hour[4:0]});
    tmAdv = tm_r;
    tmAdv.sec = cMin ? 8'h00 : bcdInc(tm_r.sec);
    if (cMin)
      tmAdv.min = cHour ? 8'h00 : bcdInc(tm_r.min);
    if (cHour)
    begin
      if (tm_r.hour[HOUR_FORMAT_24])
      begin
        cDay = tm_r.hour[5:0] == 6'h23;
        tmAdv.hour = cDay ? 8'h80 : bcdInc(tm_r.hour);
      end
      else if (tm_r.hour[4:0] == 5'h12)
        tmAdv.hour = {tm_r.hour[7:5], 5'h01};
      else if (tm_r.hour[4:0] == 5'h11)
      begin
        cDay = tm_r.hour[HOUR_PM];
        tmAdv.hour = {tm_r.hour[7:6], ~tm_r.hour[HOUR_PM], 5'h12};
      end
      else
        tmAdv.hour = {tm_r.hour[7:5], hInc[4:0]};
    end
    cMonth = cDay && tm_r.date >= lastDay;
    cYear = cMonth && tm_r.month >= 8'h12;
    if (cDay)
    begin
      tmAdv.dow = (tm_r.dow >= 8'h06) ? 8'h00 : tm_r.dow + 8'h01;
      tmAdv.date = cMonth ? 8'h01 : bcdInc(tm_r.date);
    end
    if (cMonth)
      tmAdv.month = cYear ? 8'h01 : bcdInc(tm_r.month);
    if (cYear)
      tmAdv.year = (tm_r.year == 8'h99) ? 8'h00 : bcdInc(tm_r.year);
  end

  // a host write wins over a tick in the same cycle
  always_comb
  begin
    tmNxt = secTick ? tmAdv : tm_r;
    if (timeWr)
    begin
      unique case (ptr_r)
        OFS_SEC: tmNxt.sec = {1'b0, shift_r[6:0]};
        OFS_MIN: tmNxt.min = {1'b0, shift_r[6:0]};
        OFS_HOUR: tmNxt.hour = {shift_r[7], 1'b0, shift_r[5:0]};
        OFS_DATE: tmNxt.date = {2'h0, shift_r[5:0]};
        OFS_MONTH: tmNxt.month = {3'h0, shift_r[4:0]};
        OFS_YEAR: tmNxt.year = shift_r;
        default: tmNxt.dow = {5'h00, shift_r[2:0]};
      endcase
    end
  end

  // alarm compares on the updated time
  wire fmt1 = alarm_r[2][6] == tm_r.hour[HOUR_FORMAT_24];
  wire fmt2 = alarm_r[7][6] == tm_r.hour[HOUR_FORMAT_24];
  wire [6:0] hourKey = {tm_r.hour[7], tm_r.hour[5:0]};
  wire m1 = (~alarm_r[0][7] | alarm_r[0][6:0] == tm_r.sec[6:0]) &
    (~alarm_r[1][7] | alarm_r[1][6:0] == tm_r.min[6:0]) &
    (~alarm_r[2][7] | alarm_r[2][6:0] == hourKey) &
    (~alarm_r[3][7] | alarm_r[3][5:0] == tm_r.date[5:0]) &
    (~alarm_r[4][7] | alarm_r[4][4:0] == tm_r.month[4:0]) &
    (~alarm_r[5][7] | alarm_r[5][2:0] == tm_r.dow[2:0]);
  wire m2Day = alarm_r[8][6] ? alarm_r[8][2:0] == tm_r.dow[2:0] :
    alarm_r[8][5:0] == tm_r.date[5:0];
  wire m2 = (~alarm_r[6][7] | alarm_r[6][6:0] == tm_r.min[6:0]) &
    (~alarm_r[7][7] | alarm_r[7][6:0] == hourKey) &
    (~alarm_r[8][7] | m2Day) & tm_r.sec == 8'h00;
  wire al1Hit = tickDly_r & ctrl_r[CT_AL1EN] & fmt1 & m1;
  wire al2Hit = tickDly_r & ctrl_r[CT_AL2EN] & fmt2 & m2;
  wire autoClr = busStop & statusRead_r & status_r[ST_AUTOCLR];

  // register file
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tm_r <= {ZERO_RST, ZERO_RST, ZERO_RST, DATE_RST, MONTH_RST,
        ZERO_RST, ZERO_RST};
      snap_r <= '0;
      status_r <= STATUS_RST;
      ctrl_r <= CTRL_RST;
      for (int i = 0; i < 9; i++)
        alarm_r[i] <= ZERO_RST;
    end
    else
    begin
      tm_r <= tmNxt;
      if (readStart)
        snap_r <= tm_r;
      if (ctWr)
        ctrl_r <= shift_r & CTRL_WMASK;
      if (almWr)
        alarm_r[almIdx[3:0]] <= shift_r;
      if (stWr)
      begin
        status_r[ST_AUTOCLR] <= shift_r[ST_AUTOCLR];
        status_r[ST_OSCDIS] <= shift_r[ST_OSCDIS];
        status_r[ST_WREN] <= shift_r[ST_WREN];
      end
      if (oscGone_r)
        status_r[ST_OSCFAIL] <= 1'b1;
      else if (stWr && !shift_r[ST_OSCFAIL])
        status_r[ST_OSCFAIL] <= 1'b0;
      if (al1Hit)
        status_r[ST_AL1] <= 1'b1;
      else if ((stWr && !shift_r[ST_AL1]) || autoClr)
        status_r[ST_AL1] <= 1'b0;
      if (al2Hit)
        status_r[ST_AL2] <= 1'b1;
      else if ((stWr && !shift_r[ST_AL2]) || autoClr)
        status_r[ST_AL2] <= 1'b0;
      if (timeWr)
        status_r[ST_PWRLOSS] <= 1'b0;
    end
  end

  // shared pin: frequency, open interrupt or released
  logic foutLevel;
  always_comb
  begin
    unique case ({ctrl_r[CT_FSELHI], ctrl_r[CT_FSELLO]})
      2'b11: foutLevel = xtS2;
      2'b10: foutLevel = presc_r[1];
      2'b01: foutLevel = presc_r[2];
      default: foutLevel = presc_r[PRESC_W-1];
    endcase
  end
  wire irqActive = status_r[ST_AL1] & ctrl_r[CT_AL1EN];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut_r <= 1'b1;
      pinOe_n_r <= 1'b0;
    end
    else
    begin
      pinOut_r <= ctrl_r[CT_IRQSEL] ? 1'b0 : foutLevel;
      pinOe_n_r <= ctrl_r[CT_IRQSEL] ?
        ~(ctrl_r[CT_AL1PIN] & irqActive) : 1'b0;
    end
  end

  assign irqFoutOut = pinOut_r;
  assign irqFoutOe_n = pinOe_n_r;
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~sdaDrv_r;
  assign crystalEnable = ~status_r[ST_OSCDIS];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_sec_bcd: assert property (tm_r.sec <= 8'h59 && tm_r.sec[3:0] <= 4'h9
    && tm_r.min <= 8'h59)
    else $error("seconds or minutes out of range");
  chk_sec_wrap: assert property (secTick && !timeWr && tm_r.sec == 8'h59
    |=> tm_r.sec == 8'h00 && tm_r.min != $past(tm_r.min))
    else $error("seconds did not wrap with carry");
  chk_dow_wrap: assert property ($changed(tm_r.dow) && !$past(timeWr)
    |-> tm_r.dow == 8'h00 && $past(tm_r.dow) == 8'h06 ||
    tm_r.dow == $past(tm_r.dow) + 8'h01)
    else $error("weekday stepped wrongly");
  chk_write_gate: assert property (wrStb && isTime && !status_r[ST_WREN]
    && !secTick |=> $stable(tm_r))
    else $error("time changed without write enable");
  chk_pf_clear: assert property (timeWr |=> !status_r[ST_PWRLOSS])
    else $error("power loss flag not cleared");
  chk_alarm_set: assert property (al1Hit |=> status_r[ST_AL1])
    else $error("alarm one flag not set");
  chk_flag_clear: assert property ($fell(status_r[ST_AL2]) |->
    $past(stWr) || $past(autoClr))
    else $error("alarm two flag dropped without cause");
  chk_osc_fail: assert property (oscGone_r |=> status_r[ST_OSCFAIL])
    else $error("oscillator fail flag not set");
  chk_pin_irq: assert property (ctrl_r[CT_IRQSEL] && ctrl_r[CT_AL1PIN] &&
    irqActive |=> !irqFoutOe_n && !irqFoutOut)
    else $error("interrupt pin not pulled low");
  chk_pin_hiz: assert property (ctrl_r[CT_IRQSEL] && !ctrl_r[CT_AL1PIN]
    |=> irqFoutOe_n)
    else $error("pin driven while released");

endmodule

// ---- tb/i2c_host_model.sv ----
/*
 * Serial bus master model for the clock core's register port.
 * Assumes a pull-up resolves sda outside; scl is driven push-pull.
 */
`timescale 1ns/1ps
module i2c_host_model
(
  // clock
  input wire logic clk,
  // bus
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  localparam int Q = 12;

  initial
  begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic q();
    repeat (Q) @(posedge clk);
  endtask

  // also serves as repeated start from scl low
  task automatic start();
    sdaLow <= 1'b0;
    q();
    sclOut <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    sclOut <= 1'b0;
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    q();
    sclOut <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask

  // data set while scl low, sampled while scl high
  task automatic bit_x(input logic b, output logic r);
    sdaLow <= !b;
    q();
    sclOut <= 1'b1;
    q();
    r = sdaWire;
    q();
    sclOut <= 1'b0;
    q();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ackIn,
                      output logic [7:0] rx, output logic ackOut);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(tx[i], r);
      rx[i] = r;
    end
    bit_x(ackIn, ackOut);
  endtask
endmodule

// ---- tb/bcd_rtc_status_control_bench.sv ----
/*
 * Self-checking bench of the clock core: reset values, write gating,
 * flag access, time fields, pin modes and oscillator watch.
 * Assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h want %h", $time, got, exp); \
    end \
  end
module bcd_rtc_status_control_bench
  import rtc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal = 1'b0;
  logic sclOut, hostLow, sdaOut, sdaOe_n, crystalEnable;
  logic irqFoutOut, irqFoutOe_n, ak;
  wire sdaWire = !sdaOe_n ? sdaOut : !hostLow;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 2477;
  int n;
  int fexp [4] = '{2, 10, 20, 80};
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [9];
  logic [7:0] expReg [32];

  always #2.5 clk = ~clk;
  // crystal toggles on clk falling edges, stands still while disabled
  always #40 xtal = crystalEnable ? ~xtal : xtal;

  // short prescaler: a second lasts 1024 clocks, so alarm one fires in the run
  rtc_core #(.OSC_TIMEOUT(200), .PRESC_W(6)) dut_u (
    .clk(clk), .rst_n(rst_n), .sclIn(sclOut), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .crystalInPin(xtal),
    .crystalEnable(crystalEnable), .irqFoutOut(irqFoutOut),
    .irqFoutOe_n(irqFoutOe_n)
  );

  i2c_host_model host_u (
    .clk(clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaLow(hostLow)
  );

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  function automatic int rnd(input int m);
    return ($random(seed) & 32'h7fffffff) % m;
  endfunction

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic sel(input logic rd);
    logic [7:0] rx;
    host_u.start();
    host_u.xfer({SLAVE_ADDR, rd}, 1'b1, rx, ak);
    `CHK(ak, 1'b0)
  endtask

  task automatic wr_regs(input logic [4:0] a, input int cnt);
    logic [7:0] rx;
    sel(1'b0);
    host_u.xfer({3'h0, a}, 1'b1, rx, ak);
    for (int i = 0; i < cnt; i++)
      host_u.xfer(wbuf[i], 1'b1, rx, ak);
    host_u.stop();
  endtask

  task automatic cmp(input logic [4:0] a, input int cnt);
    logic [7:0] rx;
    logic [4:0] p;
    sel(1'b0);
    host_u.xfer({3'h0, a}, 1'b1, rx, ak);
    sel(1'b1);
    for (int i = 0; i < cnt; i++)
      host_u.xfer(8'hff, i == cnt - 1, rbuf[i], ak);
    host_u.stop();
    for (int i = 0; i < cnt; i++)
    begin
      p = a + 5'(i);
      `CHK(rbuf[i], expReg[p])
    end
  endtask

  task automatic edges(output int cnt);
    logic last;
    cnt = 0;
    last = irqFoutOut;
    repeat (1280)
    begin
      @(posedge clk);
      #1;
      if (irqFoutOut === 1'b1 && last === 1'b0)
        cnt++;
      last = irqFoutOut;
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (expReg[i])
      expReg[i] = ZERO_RST;
    expReg[OFS_DATE] = DATE_RST;
    expReg[OFS_MONTH] = MONTH_RST;
    expReg[OFS_STATUS] = STATUS_RST;
    expReg[OFS_CTRL] = CTRL_RST;
    cmp(OFS_SEC, 9);
    host_u.start();
    host_u.xfer(8'ha0, 1'b1, rbuf[0], ak);
    host_u.stop();
    `CHK(ak, 1'b1)
    // locked time write
    wbuf[0] = 8'h25;
    wr_regs(OFS_SEC, 1);
    cmp(OFS_SEC, 1);
    cmp(OFS_STATUS, 1);
    // unlock, stop the crystal so time holds, try to set alarm flags
    wbuf[0] = 8'h56;
    wr_regs(OFS_STATUS, 1);
    `CHK(crystalEnable, 1'b0)
    expReg[OFS_STATUS] = 8'h59;
    cmp(OFS_STATUS, 1);
    for (int k = 0; k < 2; k++)
    begin
      wbuf[0] = bcd(rnd(60));
      wbuf[1] = bcd(rnd(60));
      wbuf[2] = k ? bcd(rnd(12) + 1) | 8'h20 : bcd(rnd(24)) | 8'h80;
      wbuf[3] = bcd(rnd(28) + 1);
      wbuf[4] = bcd(rnd(12) + 1);
      wbuf[5] = bcd(rnd(100));
      wbuf[6] = bcd(rnd(7));
      for (int i = 0; i < 7; i++)
        expReg[i] = wbuf[i];
      wr_regs(OFS_SEC, 7);
      expReg[OFS_STATUS] = 8'h58;
      cmp(OFS_SEC, 8);
    end
    // unmapped place and pointer wrap
    wbuf[0] = 8'hff;
    wr_regs(5'h0a, 1);
    cmp(5'h0a, 1);
    cmp(5'h1f, 2);
    // restart the crystal; fail flag holds, no oscillation at the write
    wbuf[0] = 8'h10;
    wr_regs(OFS_STATUS, 1);
    expReg[OFS_STATUS] = 8'h18;
    cmp(OFS_STATUS, 1);
    for (int c = 3; c >= 0; c--)
    begin
      wbuf[0] = {3'h0, 2'(c), 3'h0};
      wr_regs(OFS_CTRL, 1);
      edges(n);
      `CHK(irqFoutOe_n, 1'b0)
      `CHK(n >= fexp[c] - 1 && n <= fexp[c] + 1, 1'b1)
    end
    wbuf[0] = 8'h04;
    wr_regs(OFS_CTRL, 1);
    `CHK(irqFoutOe_n, 1'b1)
    // alarm two minute compare can never match; alarm one every second
    wbuf[0] = 8'hff;
    wr_regs(OFS_ALM1 + 5'h06, 1);
    wr_regs(OFS_CTRL, 1);
    expReg[OFS_CTRL] = CTRL_WMASK;
    cmp(OFS_CTRL, 1);
    `CHK(irqFoutOe_n === 1'b0 && irqFoutOut === 1'b0, 1'b1)
    // stop the oscillator, then try to clear osc fail
    wbuf[0] = 8'h50;
    wr_regs(OFS_STATUS, 1);
    `CHK(crystalEnable, 1'b0)
    repeat (400) @(posedge clk);
    wr_regs(OFS_STATUS, 1);
    expReg[OFS_STATUS] = 8'h58;
    cmp(OFS_STATUS, 1);
    wbuf[0] = 8'h10;
    wr_regs(OFS_STATUS, 1);
    `CHK(crystalEnable, 1'b1)
    repeat (400) @(posedge clk);
    wr_regs(OFS_STATUS, 1);
    expReg[OFS_STATUS] = 8'h14;
    cmp(OFS_STATUS, 1);
    // auto clear: a status read closed by stop drops the alarm flag
    wbuf[0] = 8'h90;
    wr_regs(OFS_STATUS, 1);
    expReg[OFS_STATUS] = 8'h94;
    cmp(OFS_STATUS, 1);
    `CHK(irqFoutOe_n, 1'b1)
    tally_and_finish();
  end
endmodule
